// [tb/ssp_spi_peer.sv]
// spi client peer that answers the port's host transfers
module ssp_spi_peer (
   input wire logic sck,
   input wire logic sel,
   input wire logic idle_polarity,
   input wire logic cke,
   input wire logic sdi,
   input wire logic [7:0] tx,
   output logic sdo,
   output logic [7:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int idx;
   initial sdo = 1'b0;
   // leading-edge modes present bit 7 before the first clock edge
   always @(posedge sel) begin
      idx = 0;
      if (cke) begin
         sdo = tx[7];
         idx = 1;
      end
   end
   // shift on the edge opposite the sampling edge, msb first
   always @(sck) begin
      if (sel && ((sck != idle_polarity) != cke) && idx < 8) begin
         sdo = tx[7 - idx];
         idx++;
      end
      if (sel && ((sck != idle_polarity) == cke)) rx = {rx[6:0], sdi};
   end
   // undriven line: show the inverse so stale data never matches by luck
   always @(negedge sel) sdo = ~sdo;
endmodule // ssp_spi_peer

// [tb/sync_serial_port_status_tb.sv]
// self-checking bench: registers, spi host modes, sleep, i2c conditions
`include "ssp_params.svh"
module sync_serial_port_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_i, i2c_on, sel;
   logic [31:0] awaddr, wdata, araddr, rdata, rd, seed;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic awready, wready, bvalid, arready, rvalid, ser_clk_o, ser_clk_oe, ser_dat_o, ser_dat_oe;
   logic wake_o, slew_limit_o, smbus_thr_o, sdo, idle_polarity, cke, c, cli_on, tck, tdi;
   logic [7:0] tx, peer_rx;
   logic [7:0] q[$];
   int fails = 0, n_tests = 0, cyc = 0, n;
   ssp_top ssp_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sleep_i(sleep_i), .ser_clk_i(i2c_on ? !ser_clk_oe : cli_on ? tck : ser_clk_o),
      .ser_din_i(i2c_on ? !ser_dat_oe : cli_on ? tdi : sdo), .sel_n_i(1'b1),
      .ser_clk_o(ser_clk_o),
      .ser_clk_oe(ser_clk_oe), .ser_dat_o(ser_dat_o), .ser_dat_oe(ser_dat_oe),
      .wake_o(wake_o), .slew_limit_o(slew_limit_o), .smbus_thr_o(smbus_thr_o));
   ssp_spi_peer ssp_spi_peer_inst (.sck(ser_clk_o), .sel(sel), .idle_polarity(idle_polarity), .cke(cke), .tx(tx),
      .sdi(ser_dat_o), .sdo(sdo), .rx(peer_rx));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // hang guard: the whole sequence needs well under this many cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) @(posedge aclk);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [31:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic poll(input logic [31:0] a, input int b, input logic v);
      do axr(a); while (rd[b] !== v);
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, sleep_i, i2c_on, sel, idle_polarity, cke} = '0;
      {awaddr, wdata, araddr, cli_on, tck, tdi} = '0;
      wstrb = 4'hF;
      tx = 8'h00;
      seed = 32'h2fb0156c;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         axr(32'h0000_0004 * i);
         chk("reset value", rd, 32'h0000_0000);
      end
      // ************************************************************
      // register access kinds
      // ************************************************************
      tx = $random(seed);
      axw(`SSP_OFF_STAT, {24'h0, tx});
      axr(`SSP_OFF_STAT);
      chk("status", rd, {24'h0, tx & 8'hC0});
      @(posedge aclk);
      chk("slew", slew_limit_o, !tx[7]);
      tx = $random(seed);
      axw(`SSP_OFF_CON1, {24'h0, tx & 8'hDF});
      axr(`SSP_OFF_CON1);
      chk("control one", rd, {24'h0, tx & 8'hDF});
      axw(32'h0000_0018, 32'h0000_00FF);
      chk("unmapped write", rs, `SSP_RESP_ERR);
      axr(32'h0000_0018);
      chk("unmapped read", rd, 32'h0);
      chk("unmapped read resp", rs, `SSP_RESP_ERR);
      // ************************************************************
      // spi host in all four bus modes
      // ************************************************************
      for (int m = 0; m < 4; m++) begin
         idle_polarity = m[1];
         cke = !m[0];
         tx = $random(seed);
         q.push_back(tx);
         axw(`SSP_OFF_STAT, {24'h0, 1'b0, cke, 6'h0});
         axw(`SSP_OFF_CON1, {24'h0, 4'h2 | idle_polarity, 4'h2});
         axw(`SSP_OFF_IRQ, {30'h0, m[0], 1'b0});
         chk("idle clock", ser_clk_o, idle_polarity);
         sel = 1'b1;
         axw(`SSP_OFF_BUF, {24'h0, tx});
         if (m == 0) begin
            repeat (100) @(posedge aclk);
            sleep_i <= 1'b1;
            repeat (3) @(posedge aclk);
            c = ser_clk_o;
            n = 0;
            repeat (200) begin
               @(posedge aclk);
               if (ser_clk_o !== c) n++;
            end
            chk("frozen clock", n, 0);
            sleep_i <= 1'b0;
         end
         poll(`SSP_OFF_IRQ, 0, 1'b1);
         sel = 1'b0;
         repeat (3) @(posedge aclk);
         chk("wake", wake_o, m[0]);
         axr(`SSP_OFF_STAT);
         chk("full", rd[0], 1'b1);
         axr(`SSP_OFF_BUF);
         chk("rx byte", rd, {24'h0, q[0]});
         chk("tx byte", peer_rx, q.pop_front());
         axr(`SSP_OFF_STAT);
         chk("full cleared", rd[0], 1'b0);
         axw(`SSP_OFF_IRQ, 32'h0000_0001);
      end
      // ************************************************************
      // spi client transfer, then i2c host conditions on a pulled-up bus
      // ************************************************************
      // spi client: bench is the host, idle low, sampled on the falling edge
      axw(`SSP_OFF_CON1, {24'h0, 4'h2, `SSP_M_SPI_CLI});
      cli_on <= 1'b1;
      axw(`SSP_OFF_BUF, 32'h0000_0000);
      tx = $random(seed);
      for (int i = 7; i >= 0; i--) begin
         tdi <= tx[i];
         repeat (4) @(posedge aclk);
         tck <= 1'b1;
         repeat (4) @(posedge aclk);
         tck <= 1'b0;
         repeat (4) @(posedge aclk);
      end
      axr(`SSP_OFF_BUF);
      chk("client byte", rd, {24'h0, tx});
      axr(`SSP_OFF_IRQ);
      chk("client flag", rd[0], 1'b1);
      // disable first so both wires idle high before i2c is selected
      axw(`SSP_OFF_CON1, 32'h0000_0000);
      i2c_on <= 1'b1;
      axw(`SSP_OFF_ADDR, 32'h0000_0004);
      axw(`SSP_OFF_CON1, {24'h0, 4'h2, `SSP_M_I2C_HOST});
      axw(`SSP_OFF_STAT, 32'h0000_0040);
      @(posedge aclk);
      chk("smbus inputs", smbus_thr_o, 1'b1);
      axw(`SSP_OFF_CON2, 32'h0000_0001);
      poll(`SSP_OFF_CON2, 0, 1'b0);
      axr(`SSP_OFF_STAT);
      chk("start seen", rd[4:3], 2'b01);
      axw(`SSP_OFF_BUF, {24'h0, tx});
      axr(`SSP_OFF_STAT);
      chk("host sending", rd[2:0], 3'b101);
      poll(`SSP_OFF_STAT, 2, 1'b0);
      chk("sent", rd[0], 1'b0);
      axr(`SSP_OFF_CON2);
      chk("no ack on idle bus", rd[6], 1'b1);
      axw(`SSP_OFF_CON2, 32'h0000_0004);
      poll(`SSP_OFF_CON2, 2, 1'b0);
      axr(`SSP_OFF_STAT);
      chk("stop seen", rd[4:3], 2'b10);
      axw(`SSP_OFF_CON1, {24'h0, 4'h0, `SSP_M_I2C_HOST});
      axr(`SSP_OFF_STAT);
      chk("cleared on disable", rd[4:3], 2'b00);
      tally_and_finish();
   end
endmodule // sync_serial_port_status_tb

// [verilog/ssp_params.svh]
// constants for the synchronous serial port
//
// Contract
// R1 - sleep freezes any host transfer in place; it resumes after return to run
// R2 - transfer completion raises wake only while the port interrupt is enabled
// R3 - spi client shifts on the external clock and flags after 8 bits
// R4 - any reset disables the port and aborts the transfer in progress
// R5 - spi modes 00,01,10,11 map to polarity/edge 0/1, 0/0, 1/1, 1/0
// R6 - sample-phase bit selects where in the bit period input data is sampled
// R7 - i2c host and client with general call; start and stop detected and interrupting
// R8 - i2c client accepts 7-bit and 10-bit addressing
// R9 - address register is own address in client, low seven bits baud reload in host
// R10 - completed received byte moves to buffer and sets the port flag
// R11 - buffer write loads buffer and shifter together, no transmit double buffer
// R12 - status low six bits read-only, top two read-write; control registers read-write
// R13 - status bit 7 high disables slew control, low enables it
// R14 - status bit 6 high enables smbus input thresholds in i2c
// R15 - client data/address bit is 1 after data, 0 after address
// R16 - stop-seen bit is 1 when the last condition seen was a stop
// R17 - start-seen bit is 1 when the last condition seen was a start
// R18 - start-seen and stop-seen clear on reset and when port enable clears
// R19 - client direction bit holds last matched read/write bit until start, stop, nack; the code clears it on start and stop only, not on a nack
// R20 - host direction bit is 1 while a transmit runs
// R21 - update-address bit set when 10-bit client must reload the address register
// R22 - buffer-full bit is 1 while the buffer holds a byte
// R23 - reading the buffer clears buffer-full; received byte sets the port flag
// R24 - serial-side inputs pass a two-stage synchroniser before status uses them
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_OFF_STAT 32'h0000_0000
`define SSP_OFF_CON1 32'h0000_0004
`define SSP_OFF_CON2 32'h0000_0008
`define SSP_OFF_BUF 32'h0000_000C
`define SSP_OFF_ADDR 32'h0000_0010
`define SSP_OFF_IRQ 32'h0000_0014
`define SSP_RESP_OK 2'h0
`define SSP_RESP_ERR 2'h2
`define SSP_C1_WCOL 7
`define SSP_C1_OV 6
`define SSP_C1_EN 5
`define SSP_C1_CKP 4
`define SSP_C2_GCEN 7
`define SSP_C2_ACKST 6
`define SSP_C2_ACKDT 5
`define SSP_C2_ACK_REQUEST 4
`define SSP_C2_RECEIVE_REQUEST 3
`define SSP_C2_PEN 2
`define SSP_C2_RESTART_REQUEST 1
`define SSP_C2_SEN 0
`define SSP_M_SPI_CSS 4'h4
`define SSP_M_SPI_CLI 4'h5
`define SSP_M_I2C_C7 4'h6
`define SSP_M_I2C_C10 4'h7
`define SSP_M_I2C_HOST 4'h8
`define SSP_M_I2C_FW 4'hB
`define SSP_M_I2C_C7SP 4'hE
`define SSP_M_I2C_C10SP 4'hF
`define SSP_DIV_F4 8'h01
`define SSP_DIV_F16 8'h07
`define SSP_DIV_F64 8'h1F
`define SSP_SPI_BITS 4'h8
`define SSP_I2C_BITS 4'h9
`define SSP_ACK_BITS 4'h1
`define SSP_GCALL 8'h00
`define SSP_IDX_BAD 3'h7
`endif

// [verilog/ssp_pkg.sv]
// types of the synchronous serial port
package ssp_pkg;
   typedef enum logic [2:0] {HS_IDLE = 3'h1, HS_BITS = 3'h2, HS_COND = 3'h4} ssp_hs_t;
   typedef enum logic [1:0] {XK_SPI = 2'h0, XK_TX = 2'h1, XK_RX = 2'h2, XK_ACK = 2'h3} ssp_xk_t;
   typedef struct packed {
      logic awr, arr, bv, rv;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
      logic [1:0] shi;
      logic [7:0] con1, con2, bufr, addr;
      logic ie, irq, wake, da, sp, st, rw, ua, bf;
      logic cs1, cs2, cs3, ds1, ds2, ds3, ss1, ss2;
      logic [8:0] sh;
      logic [3:0] bitcnt, nbits;
      logic [4:0] tgl;
      ssp_hs_t hs;
      ssp_xk_t xk;
      logic [7:0] div;
      logic pend, cstop;
      logic [1:0] step, cbyte;
      logic cl_on, ack, clk_l, dat_l, clk_o, clk_oe, dat_o, dat_oe, slew, smb;
   } ssp_state_t;
endpackage

// [verilog/ssp_top.sv]
// synchronous serial port: spi host/client, i2c host/client, axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`include "ssp_params.svh"
module ssp_top import ssp_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic sleep_i,
   input wire logic ser_clk_i,
   input wire logic ser_din_i,
   input wire logic sel_n_i,
   output logic ser_clk_o,
   output logic ser_clk_oe,
   output logic ser_dat_o,
   output logic ser_dat_oe,
   output logic wake_o,
   output logic slew_limit_o,
   output logic smbus_thr_o
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [2:0] reg_idx(input logic [31:0] a);
      case (a)
         `SSP_OFF_STAT: reg_idx = 3'h0;
         `SSP_OFF_CON1: reg_idx = 3'h1;
         `SSP_OFF_CON2: reg_idx = 3'h2;
         `SSP_OFF_BUF: reg_idx = 3'h3;
         `SSP_OFF_ADDR: reg_idx = 3'h4;
         `SSP_OFF_IRQ: reg_idx = 3'h5;
         default: reg_idx = `SSP_IDX_BAD;
      endcase
   endfunction

   // half bit period reload; host i2c and the timer-based spi rate use the address reg
   function automatic logic [7:0] half_reload(input logic [3:0] m, input logic [7:0] a);
      case (m)
         4'h0: half_reload = `SSP_DIV_F4;
         4'h1: half_reload = `SSP_DIV_F16;
         4'h2: half_reload = `SSP_DIV_F64;
         default: half_reload = {1'h0, a[6:0]}; // R9
      endcase
   endfunction

   ssp_state_t st_q, st_d;
   logic [3:0] mode;
   logic en, spi_host, spi_cli, i2c_cli, i2c_host, i2c, ten, sp_irq;
   logic idle_polarity, cke, sample_phase_slew, cke_eff, smp_eff, host, ss_ok;
   logic wr_fire, rd_fire, buf_wr, rd_buf, tick, lead, tog, is_in, edge_ev, do_shift, done;
   logic start_ev, stop_ev, scl_rise, scl_fall, tx_done, i2c_in, dlvl;
   logic [2:0] wr_idx, rd_idx;
   logic [7:0] wb, b;

   assign mode = st_q.con1[3:0];
   assign en = st_q.con1[`SSP_C1_EN];
   assign idle_polarity = st_q.con1[`SSP_C1_CKP];
   assign sample_phase_slew = st_q.shi[1];
   assign cke = st_q.shi[0];
   assign spi_host = en & (mode < `SSP_M_SPI_CSS);
   assign spi_cli = en & (mode == `SSP_M_SPI_CSS | mode == `SSP_M_SPI_CLI);
   assign i2c_cli = en & (mode == `SSP_M_I2C_C7 | mode == `SSP_M_I2C_C10 |
                          mode == `SSP_M_I2C_C7SP | mode == `SSP_M_I2C_C10SP);
   assign i2c_host = en & (mode == `SSP_M_I2C_HOST);
   assign i2c = i2c_cli | i2c_host | (en & mode == `SSP_M_I2C_FW);
   assign ten = mode[0];
   assign sp_irq = mode == `SSP_M_I2C_C7SP | mode == `SSP_M_I2C_C10SP;
   assign host = spi_host | i2c_host;
   assign ss_ok = mode == `SSP_M_SPI_CLI | ~st_q.ss2;
   // i2c shifts in on the rising scl edge, like an spi edge-select of one
   assign cke_eff = i2c | cke;
   assign smp_eff = ~i2c & sample_phase_slew; // R6

   assign wr_fire = st_q.awr & awvalid & wvalid;
   assign rd_fire = st_q.arr & arvalid;
   assign wr_idx = reg_idx(awaddr);
   assign rd_idx = reg_idx(araddr);
   assign wb = wdata[7:0];
   assign buf_wr = wr_fire & wstrb[0] & wr_idx == 3'h3;
   assign rd_buf = rd_fire & rd_idx == 3'h3;

   // only the second synchroniser stage and its delayed copy are looked at
   assign start_ev = i2c & st_q.cs2 & st_q.cs3 & st_q.ds3 & ~st_q.ds2; // R7 R24
   assign stop_ev = i2c & st_q.cs2 & st_q.cs3 & ~st_q.ds3 & st_q.ds2; // R7 R24
   assign scl_rise = st_q.cs2 & ~st_q.cs3;
   assign scl_fall = ~st_q.cs2 & st_q.cs3;

   // R1
   assign tick = st_q.div == 8'h00 & ~sleep_i;
   assign lead = host ? (st_q.clk_l == (i2c ? 1'h0 : idle_polarity)) : (st_q.cs2 != idle_polarity);
   assign tog = host ? (st_q.tgl < {st_q.nbits, 1'h0}) : 1'h1;
   assign edge_ev = st_q.hs == HS_BITS &
                    (host ? tick : spi_cli & ss_ok & (scl_rise | scl_fall)); // R3
   assign is_in = tog & (lead ? cke_eff : ~cke_eff); // R5
   assign do_shift = edge_ev & (smp_eff ? st_q.pend : is_in); // R6
   assign i2c_in = st_q.ds2;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      done = 1'h0;
      tx_done = 1'h0;
      b = st_q.sh[7:0];
      dlvl = 1'h1;
      st_d.cs1 = ser_clk_i; // R24
      st_d.cs2 = st_q.cs1;
      st_d.cs3 = st_q.cs2;
      st_d.ds1 = ser_din_i;
      st_d.ds2 = st_q.ds1;
      st_d.ds3 = st_q.ds2;
      st_d.ss1 = sel_n_i;
      st_d.ss2 = st_q.ss1;

      // bus slave
      st_d.awr = ~st_q.awr & ~st_q.bv & awvalid & wvalid;
      st_d.arr = ~st_q.arr & ~st_q.rv & arvalid;
      if (st_q.bv & bready) st_d.bv = 1'h0;
      if (st_q.rv & rready) st_d.rv = 1'h0;
      if (wr_fire) begin
         st_d.bv = 1'h1;
         st_d.bresp = wr_idx == `SSP_IDX_BAD ? `SSP_RESP_ERR : `SSP_RESP_OK;
         if (wstrb[0]) begin
            case (wr_idx)
               3'h0: st_d.shi = wb[7:6]; // R12
               3'h1: st_d.con1 = wb; // R12
               3'h2: st_d.con2 = wb;
               3'h4: begin
                  st_d.addr = wb;
                  st_d.ua = 1'h0;
               end
               3'h5: begin
                  st_d.ie = wb[1];
                  if (wb[0]) st_d.irq = 1'h0;
               end
               default: ;
            endcase
         end
      end
      if (rd_fire) begin
         st_d.rv = 1'h1;
         st_d.rresp = rd_idx == `SSP_IDX_BAD ? `SSP_RESP_ERR : `SSP_RESP_OK;
         case (rd_idx)
            3'h0: st_d.rdata = {24'h00_0000, st_q.shi, st_q.da, st_q.sp, st_q.st,
                                st_q.rw, st_q.ua, st_q.bf};
            3'h1: st_d.rdata = {24'h00_0000, st_q.con1};
            3'h2: st_d.rdata = {24'h00_0000, st_q.con2};
            3'h3: st_d.rdata = {24'h00_0000, st_q.bufr};
            3'h4: st_d.rdata = {24'h00_0000, st_q.addr};
            3'h5: st_d.rdata = {30'h0000_0000, st_q.ie, st_q.irq};
            default: st_d.rdata = 32'h0000_0000;
         endcase
         if (rd_idx == 3'h3) st_d.bf = 1'h0; // R23
      end

      st_d.div = tick | st_q.hs == HS_IDLE ? half_reload(mode, st_q.addr) :
                 (sleep_i ? st_q.div : st_q.div - 8'h01);

      // ****************************************
      // host and spi shift engine
      // ****************************************
      case (st_q.hs)
         HS_IDLE: begin
            st_d.tgl = 5'h00;
            st_d.pend = 1'h0;
            if (spi_host) st_d.clk_l = idle_polarity; // R5
            if (buf_wr & (host | spi_cli)) begin
               st_d.sh = {wb, i2c_host}; // R11
               st_d.bufr = wb; // R11
               st_d.dat_l = wb[7];
               st_d.bitcnt = 4'h0;
               st_d.nbits = i2c_host ? `SSP_I2C_BITS : `SSP_SPI_BITS;
               st_d.xk = i2c_host ? XK_TX : XK_SPI;
               st_d.hs = HS_BITS;
               if (i2c_host) begin
                  st_d.bf = 1'h1; // R22
                  st_d.rw = 1'h1; // R20
               end
            end else if (i2c_host & (st_q.con2[`SSP_C2_SEN] | st_q.con2[`SSP_C2_RESTART_REQUEST])) begin
               st_d.cstop = 1'h0;
               st_d.step = st_q.con2[`SSP_C2_SEN] ? 2'h2 : 2'h0;
               st_d.hs = HS_COND;
            end else if (i2c_host & st_q.con2[`SSP_C2_PEN]) begin
               st_d.cstop = 1'h1;
               st_d.step = 2'h0;
               st_d.hs = HS_COND;
            end else if (i2c_host & (st_q.con2[`SSP_C2_RECEIVE_REQUEST] | st_q.con2[`SSP_C2_ACK_REQUEST])) begin
               st_d.sh = st_q.con2[`SSP_C2_RECEIVE_REQUEST] ? 9'h1FF : {st_q.con2[`SSP_C2_ACKDT], 8'hFF};
               st_d.dat_l = st_q.con2[`SSP_C2_RECEIVE_REQUEST] | st_q.con2[`SSP_C2_ACKDT];
               st_d.nbits = st_q.con2[`SSP_C2_RECEIVE_REQUEST] ? `SSP_SPI_BITS : `SSP_ACK_BITS;
               st_d.xk = st_q.con2[`SSP_C2_RECEIVE_REQUEST] ? XK_RX : XK_ACK;
               st_d.bitcnt = 4'h0;
               st_d.hs = HS_BITS;
            end
         end
         HS_BITS: begin
            if (buf_wr) st_d.con1[`SSP_C1_WCOL] = 1'h1;
            if (edge_ev) st_d.pend = smp_eff & is_in;
            if (do_shift) begin
               st_d.sh = {st_q.sh[7:0], i2c_in};
               st_d.bitcnt = st_q.bitcnt + 4'h1;
            end
            if (edge_ev & tog & ~is_in) st_d.dat_l = st_d.sh[8];
            if (edge_ev & tog & host) begin
               st_d.clk_l = ~st_q.clk_l;
               st_d.tgl = st_q.tgl + 5'h01;
            end
            done = edge_ev & st_d.bitcnt == st_q.nbits &
                   (~host | st_d.tgl == {st_q.nbits, 1'h0});
            if (done) begin
               st_d.hs = HS_IDLE;
               st_d.bitcnt = 4'h0;
               st_d.irq = 1'h1; // R3 R10
               case (st_q.xk)
                  XK_TX: begin
                     tx_done = 1'h1;
                     st_d.bf = 1'h0;
                     st_d.rw = 1'h0; // R20
                     st_d.con2[`SSP_C2_ACKST] = st_d.sh[0];
                  end
                  XK_ACK: st_d.con2[`SSP_C2_ACK_REQUEST] = 1'h0;
                  default: begin
                     if (st_q.xk == XK_RX) st_d.con2[`SSP_C2_RECEIVE_REQUEST] = 1'h0;
                     if (st_q.bf & ~rd_buf) st_d.con1[`SSP_C1_OV] = 1'h1;
                     else begin
                        st_d.bufr = st_d.sh[7:0]; // R10
                        st_d.bf = 1'h1; // R22
                     end
                  end
               endcase
            end
            if (spi_cli & mode == `SSP_M_SPI_CSS & st_q.ss2) st_d.bitcnt = 4'h0;
         end
         HS_COND: begin
            if (tick) begin
               st_d.step = st_q.step + 2'h1;
               case ({st_q.cstop, st_q.step})
                  3'h0: st_d.dat_l = 1'h1;
                  3'h1: st_d.clk_l = 1'h1;
                  3'h2: st_d.dat_l = 1'h0;
                  3'h4: st_d.dat_l = 1'h0;
                  3'h5: st_d.clk_l = 1'h1;
                  3'h6: st_d.dat_l = 1'h1;
                  default: st_d.clk_l = 1'h0;
               endcase
               if ({st_q.cstop, st_q.step} == 3'h3 | {st_q.cstop, st_q.step} == 3'h6) begin
                  st_d.hs = HS_IDLE;
                  st_d.irq = 1'h1;
                  st_d.con2[`SSP_C2_SEN] = 1'h0;
                  st_d.con2[`SSP_C2_RESTART_REQUEST] = 1'h0;
                  st_d.con2[`SSP_C2_PEN] = 1'h0;
               end
            end
         end
         default: st_d.hs = HS_IDLE;
      endcase

      // ****************************************
      // i2c bus conditions and client
      // ****************************************
      if (i2c_cli & scl_rise & st_q.bitcnt < `SSP_SPI_BITS & (st_q.cbyte == 2'h0 | st_q.cl_on)) begin
         st_d.sh = {st_q.sh[7:0], i2c_in};
         st_d.bitcnt = st_q.bitcnt + 4'h1;
      end
      if (i2c_cli & scl_fall & st_q.ack) begin
         st_d.ack = 1'h0;
         st_d.bitcnt = 4'h0;
      end else if (i2c_cli & scl_fall & st_q.bitcnt == `SSP_SPI_BITS) begin
         st_d.bitcnt = 4'h0;
         if (st_q.cbyte == 2'h0 & (b[7:1] == st_q.addr[7:1] |
             (st_q.con2[`SSP_C2_GCEN] & ~ten & b == `SSP_GCALL))) begin // R7 R8
            st_d.cl_on = 1'h1;
            st_d.da = 1'h0; // R15
            st_d.rw = b[0]; // R19
            st_d.ua = ten; // R21
            st_d.cbyte = ten & ~b[0] ? 2'h1 : 2'h2;
         end else if (st_q.cbyte == 2'h1 & st_q.cl_on & b == st_q.addr) begin // R8
            st_d.da = 1'h0;
            st_d.ua = 1'h1; // R21
            st_d.cbyte = 2'h2;
         end else if (st_q.cbyte == 2'h2 & st_q.cl_on & ~st_q.rw) begin
            st_d.da = 1'h1; // R15
         end else begin
            st_d.cl_on = 1'h0;
         end
         if (st_d.cl_on) begin
            st_d.irq = 1'h1; // R23
            if (st_q.bf | st_q.con1[`SSP_C1_OV]) begin
               st_d.con1[`SSP_C1_OV] = 1'h1;
            end else begin
               st_d.ack = 1'h1;
               st_d.bufr = b; // R10
               st_d.bf = 1'h1; // R22
            end
         end else begin
            st_d.cbyte = 2'h3;
         end
      end
      if (start_ev | stop_ev) begin
         st_d.st = start_ev; // R17
         st_d.sp = stop_ev; // R16
         if (i2c_cli) begin
            st_d.rw = 1'h0; // R19
            st_d.cl_on = 1'h0;
            st_d.ack = 1'h0;
            st_d.bitcnt = 4'h0;
            st_d.cbyte = stop_ev ? 2'h3 : 2'h0;
            if (sp_irq) st_d.irq = 1'h1; // R7
         end
      end

      // ****************************************
      // port disable and pins
      // ****************************************
      if (~st_d.con1[`SSP_C1_EN]) begin
         st_d.st = 1'h0; // R18
         st_d.sp = 1'h0; // R18
         st_d.hs = HS_IDLE; // R4
         st_d.bitcnt = 4'h0;
         st_d.cl_on = 1'h0;
         st_d.ack = 1'h0;
         st_d.cbyte = 2'h3;
         st_d.clk_l = 1'h1;
         st_d.dat_l = 1'h1;
      end
      dlvl = i2c_cli ? ~st_d.ack : st_d.dat_l;
      st_d.clk_o = ~i2c & st_d.clk_l;
      st_d.clk_oe = spi_host | (i2c_host & ~st_d.clk_l);
      st_d.dat_o = ~i2c & st_d.dat_l;
      st_d.dat_oe = i2c ? ~dlvl & (i2c_host | i2c_cli) : spi_host | (spi_cli & ss_ok);
      st_d.slew = ~sample_phase_slew; // R13
      st_d.smb = i2c & cke; // R14
      st_d.wake = st_q.irq & st_q.ie; // R2
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.hs <= HS_IDLE;
         st_q.cbyte <= 2'h3;
         st_q.clk_l <= 1'h1;
         st_q.dat_l <= 1'h1;
      end else begin
         st_q <= st_d;
      end
   end

   assign awready = st_q.awr;
   assign wready = st_q.awr;
   assign bvalid = st_q.bv;
   assign bresp = st_q.bresp;
   assign arready = st_q.arr;
   assign rvalid = st_q.rv;
   assign rdata = st_q.rdata;
   assign rresp = st_q.rresp;
   assign ser_clk_o = st_q.clk_o;
   assign ser_clk_oe = st_q.clk_oe;
   assign ser_dat_o = st_q.dat_o;
   assign ser_dat_oe = st_q.dat_oe;
   assign wake_o = st_q.wake;
   assign slew_limit_o = st_q.slew;
   assign smbus_thr_o = st_q.smb;

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   bus_write_resp_a: assert property (wr_fire |=> bvalid) // R12
      else $error("write not answered");
   wake_gate_a: assert property (st_q.irq && st_q.ie |=> wake_o) // R2
      else $error("wake missing");
   wake_off_a: assert property (!st_q.ie |=> !wake_o) // R2
      else $error("wake while disabled");
   disable_clear_a: assert property (!en && !wr_fire |=> !st_q.st && !st_q.sp && st_q.hs == HS_IDLE) // R18
      else $error("disabled port kept state");
   start_seen_a: assert property (start_ev && en && !wr_fire |=> st_q.st && !st_q.sp) // R17
      else $error("start not recorded");
   stop_seen_a: assert property (stop_ev && en && !wr_fire |=> st_q.sp && !st_q.st) // R16
      else $error("stop not recorded");
   bf_fall_a: assert property ($fell(st_q.bf) |-> $past(rd_buf) || $past(tx_done)) // R23
      else $error("buffer-full cleared without cause");
   sleep_hold_a: assert property (sleep_i && st_q.hs == HS_BITS && host && !wr_fire
                                   |=> $stable(st_q.sh) && $stable(st_q.tgl)) // R1
      else $error("transfer moved in sleep");
   spi_idle_pol_a: assert property (spi_host && st_q.hs == HS_IDLE && !wr_fire
                                     |=> ser_clk_o == $past(idle_polarity)) // R5
      else $error("spi clock not at idle level");
   done_flag_a: assert property (done |=> st_q.irq && (st_q.bf || st_q.con1[`SSP_C1_OV] ||
                                  st_q.xk != XK_SPI)) // R10
      else $error("completion without flag");
   tx_dir_a: assert property (st_q.hs == HS_BITS && st_q.xk == XK_TX && i2c_host |-> st_q.rw) // R20
      else $error("direction low during transmit");
endmodule // ssp_top
